/* File: include/uphyc_regs.vh */
// Register map and constants for the USB PHY control block
// What this block does
// - Writing one to control bit 18 disables the pulldowns on both wide ports, zero (reset) keeps them enabled.
// - An automatic resume caused by SE0 reset signalling sets status bit 13, which holds until software writes zero.
// - An automatic resume caused by K resume signalling sets status bit 12, which holds until software writes zero.
// - A line-state change is reported only once it has stayed stable for one plus two to the power of field 11:8 enabled clock cycles.
// - With control bit 7 set, the suspend controller detects and handles resume in hardware.
// - The three transceiver config pins follow field 6:4 directly, all low after reset.
`ifndef UPHYC_REGS_VH
`define UPHYC_REGS_VH
`define UPHYC_ADDR_W 8
`define UPHYC_OFF_CTRL 8'h40
`define UPHYC_OFF_FILT 8'h44
`define UPHYC_OFF_IRQ_STAT 8'h48
`define UPHYC_OFF_IRQ_MASK 8'h4C
`define UPHYC_BIT_PD_DIS 18
`define UPHYC_BIT_RST_RES 13
`define UPHYC_BIT_K_RES 12
`define UPHYC_DLY_HI 11
`define UPHYC_DLY_LO 8
`define UPHYC_BIT_AUTO 7
`define UPHYC_CFG_HI 6
`define UPHYC_CFG_LO 4
`define UPHYC_CTRL_WMASK 32'h0004_3FF0
`define UPHYC_LS_SE0 2'h0
`define UPHYC_LS_J 2'h1
`define UPHYC_LS_K 2'h2
`define UPHYC_IRQ_W 3
`define UPHYC_IRQ_RST 0
`define UPHYC_IRQ_K 1
`define UPHYC_IRQ_LS 2
`define UPHYC_CNT_W 16
`endif

/* File: src/uphyc_ls_filter.v */
// Line-state change delay filter
`timescale 1ns/1ps
module uphyc_ls_filter (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [3:0] log2_dly_i,
  input wire [1:0] ls_raw_i,
  output reg [1:0] ls_filt_o,
  output reg changed_o
);
`include "uphyc_regs.vh"
  reg [1:0] cand_reg;
  reg [`UPHYC_CNT_W-1:0] cnt_reg;
  wire [`UPHYC_CNT_W-1:0] target = {{(`UPHYC_CNT_W-1){1'b0}}, 1'b1} << log2_dly_i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cand_reg <= `UPHYC_LS_J;
      cnt_reg <= {`UPHYC_CNT_W{1'b0}};
      ls_filt_o <= `UPHYC_LS_J;
      changed_o <= 1'b0;
    end else if (ce_i) begin
      changed_o <= 1'b0;
      // Any wobble restarts the count, so glitches never propagate
      if (ls_raw_i != cand_reg) begin
        cand_reg <= ls_raw_i;
        cnt_reg <= {`UPHYC_CNT_W{1'b0}};
      end else if (cand_reg != ls_filt_o) begin
        if (cnt_reg + 1'b1 >= target) begin
          ls_filt_o <= cand_reg;
          changed_o <= 1'b1;
          cnt_reg <= {`UPHYC_CNT_W{1'b0}};
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end
endmodule

/* File: src/uphyc_top.v */
// USB PHY control register with resume detection and Wishbone slave
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
module uphyc_top (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [1:0] line_state_i,
  input wire suspended_i,
  output reg [1:0] line_state_filt_o,
  output reg resume_req_o,
  output reg port_a_wide_pd_en_o,
  output reg port_b_wide_pd_en_o,
  output reg [2:0] transceiver_config_pins_o,
  output reg irq_o
);
`include "uphyc_regs.vh"
  reg [31:0] ctrl_reg;
  reg [`UPHYC_IRQ_W-1:0] irq_stat_reg;
  reg [`UPHYC_IRQ_W-1:0] irq_mask_reg;
  reg [31:0] rdata_next;
  wire [1:0] ls_filt;
  wire ls_chg;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire auto_en = ctrl_reg[`UPHYC_BIT_AUTO];
  // Resume seen by hardware only when auto mode is on and link is suspended
  wire res_rst = auto_en & suspended_i & ls_chg & (ls_filt == `UPHYC_LS_SE0);
  wire res_k = auto_en & suspended_i & ls_chg & (ls_filt == `UPHYC_LS_K);
  wire [`UPHYC_IRQ_W-1:0] ev = {ls_chg, res_k, res_rst};

  uphyc_ls_filter u_filt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .log2_dly_i(ctrl_reg[`UPHYC_DLY_HI:`UPHYC_DLY_LO]),
    .ls_raw_i(line_state_i),
    .ls_filt_o(ls_filt),
    .changed_o(ls_chg)
  );

  always @* begin
    case (wb_adr_i)
      `UPHYC_OFF_CTRL: rdata_next = ctrl_reg & `UPHYC_CTRL_WMASK;
      `UPHYC_OFF_FILT: rdata_next = {{30{1'b0}}, ls_filt};
      `UPHYC_OFF_IRQ_STAT: rdata_next = {{(32-`UPHYC_IRQ_W){1'b0}}, irq_stat_reg};
      `UPHYC_OFF_IRQ_MASK: rdata_next = {{(32-`UPHYC_IRQ_W){1'b0}}, irq_mask_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= 32'h0000_0000;
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      line_state_filt_o <= `UPHYC_LS_J;
      resume_req_o <= 1'b0;
      port_a_wide_pd_en_o <= 1'b1;
      port_b_wide_pd_en_o <= 1'b1;
      transceiver_config_pins_o <= 3'h0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rdata_next : 32'h0000_0000;
      // Writes only touch writable bits; sticky flags cleared by writing zero
      if (wr && wb_adr_i == `UPHYC_OFF_CTRL) begin
        ctrl_reg <= ((ctrl_reg & ~bmask) | (wb_dat_i & bmask)) & `UPHYC_CTRL_WMASK;
      end
      // Set wins over a simultaneous software clear
      if (res_rst) begin
        ctrl_reg[`UPHYC_BIT_RST_RES] <= 1'b1;
      end
      if (res_k) begin
        ctrl_reg[`UPHYC_BIT_K_RES] <= 1'b1;
      end
      if (wr && wb_adr_i == `UPHYC_OFF_IRQ_STAT && wb_sel_i[0]) begin
        irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[`UPHYC_IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev;
      end
      if (wr && wb_adr_i == `UPHYC_OFF_IRQ_MASK && wb_sel_i[0]) begin
        irq_mask_reg <= wb_dat_i[`UPHYC_IRQ_W-1:0];
      end
      irq_o <= |(irq_stat_reg & irq_mask_reg);
      line_state_filt_o <= ls_filt;
      resume_req_o <= res_rst | res_k;
      port_a_wide_pd_en_o <= ~ctrl_reg[`UPHYC_BIT_PD_DIS];
      port_b_wide_pd_en_o <= ~ctrl_reg[`UPHYC_BIT_PD_DIS];
      transceiver_config_pins_o <= ctrl_reg[`UPHYC_CFG_HI:`UPHYC_CFG_LO];
    end
  end
endmodule

/* File: tb/uphyc_phy_model.sv */
// Transceiver stand-in: line state and suspend
`timescale 1ns/1ps
module uphyc_phy_model (output reg [1:0] line_state_o = 2'h1, output reg suspended_o = 1'h0);
  task send(input [1:0] l, input s);
    {line_state_o, suspended_o} <= {l, s};
  endtask
endmodule

/* File: tb/uphyc_top_properties.sv */
// Port checker for the PHY control block
`timescale 1ns/1ps
module uphyc_top_properties (input wire clk_i, input wire rst_i, input wire wb_ack_o, input wire wb_we_i,
  input wire [7:0] wb_adr_i, input wire [31:0] wb_dat_o, input wire [1:0] line_state_i,
  input wire [1:0] line_state_filt_o, input wire resume_req_o, input wire port_a_wide_pd_en_o,
  input wire [2:0] transceiver_config_pins_o);
  wire wr = wb_ack_o & wb_we_i & (wb_adr_i == 8'h40);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_PD: assert property ($changed(port_a_wide_pd_en_o) |-> wr || $past(wr) || $past(wr, 2)) else $error("pd");
  AST_CF: assert property ($changed(transceiver_config_pins_o) |-> wr || $past(wr) || $past(wr, 2))
    else $error("cf");
  AST_RST: assert property ($fell(rst_i) |-> port_a_wide_pd_en_o && !transceiver_config_pins_o) else $error("rs");
  AST_LS: assert property ($changed(line_state_filt_o) |-> $past(line_state_i, 2) == line_state_filt_o)
    else $error("ls");
  AST_RES: assert property (resume_req_o |-> !line_state_filt_o[0]) else $error("re");
  AST_RSV: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h40 |-> !(wb_dat_o & 32'hFFFB_C00F))
    else $error("rv");
  AST_ACK: assert property (wb_ack_o |=> !wb_ack_o) else $error("ak");
  cover property (resume_req_o);
  cover property (wr);
  cover property ($changed(line_state_filt_o));
endmodule
bind uphyc_top uphyc_top_properties u_uphyc_top_properties (.*);

/* File: tb/uphyc_top_test.sv */
// Bench for the PHY control block
`timescale 1ns/1ps
module uphyc_top_test;
  reg clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, we = 1'h0;
  reg [7:0] a = 8'h00;
  reg [31:0] d = 32'h0000_0000;
  wire [31:0] r;
  wire [2:0] c;
  wire [1:0] ls, f;
  wire k, s, i, pa, pb, q;
  reg rq = 1'h0;
  always @(posedge clk_i) if (q) rq <= 1'h1;
  integer err_total = 0, total_checks = 0, t = 0;
  always #4 clk_i = ~clk_i;
  uphyc_phy_model u_uphyc_phy_model (.line_state_o(ls), .suspended_o(s));
  uphyc_top u_uphyc_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(a), .wb_sel_i(4'hF), .wb_dat_i(d), .wb_dat_o(r), .wb_ack_o(k), .line_state_i(ls), .suspended_i(s),
    .line_state_filt_o(f), .resume_req_o(q), .port_a_wide_pd_en_o(pa), .port_b_wide_pd_en_o(pb),
    .transceiver_config_pins_o(c), .irq_o(i));
  task cmp(input [23:0] n, input [31:0] e, input [31:0] v);
    total_checks = total_checks + 1;
    if (v !== e) $display("wrong value %s exp %h got %h", n, e, v);
    err_total = err_total + (v !== e);
  endtask
  task bus(input w, input [7:0] x, input [31:0] y, input [31:0] e);
    {cyc, we, a, d} <= {1'h1, w, x, y};
    @(posedge clk_i);
    while (k !== 1'h1) @(posedge clk_i);
    if (!w) cmp("reg", e, r);
    cyc <= 1'h0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    t <= t + 1;
    if (t == 3000) err_total = err_total + 1;
    if (t == 3000) conclude;
  end
  task conclude;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    cmp("pin", 5'h18, {pa, pb, c});
    bus(1'h1, 8'h40, 32'hFFFF_CFFF, 1'h0);
    bus(1'h0, 8'h40, 1'h0, 32'h0004_0FF0);
    cmp("pin", 5'h07, {pa, pb, c});
    // Short filter so resume shows quickly
    bus(1'h1, 8'h40, 12'h180, 1'h0);
    u_uphyc_phy_model.send(2'h2, 1'h1);
    repeat (8) @(posedge clk_i);
    cmp("ls", 2'h2, f);
    cmp("res", 1'h1, rq);
    bus(1'h0, 8'h40, 1'h0, 16'h1180);
    u_uphyc_phy_model.send(2'h0, 1'h1);
    repeat (8) @(posedge clk_i);
    bus(1'h0, 8'h40, 1'h0, 16'h3180);
    cmp("irq", 1'h0, i);
    bus(1'h1, 8'h4C, 3'h7, 1'h0);
    cmp("irq", 1'h1, i);
    bus(1'h1, 8'h48, 3'h7, 1'h0);
    cmp("irq", 1'h0, i);
    bus(1'h1, 8'h40, 1'h0, 1'h0);
    u_uphyc_phy_model.send(2'h1, 1'h0);
    repeat (4) @(posedge clk_i);
    bus(1'h0, 8'h44, 1'h0, 1'h1);
    bus(1'h0, 8'h40, 1'h0, 1'h0);
    bus(1'h0, 8'h7C, 1'h0, 1'h0);
    conclude;
  end
endmodule
